// ===== hw/dtc_pkg.sv
// Constants shared by the dual 8-bit cascadable timer
package dtc_pkg;
  // Register addresses
  localparam logic [15:0] DTC_ADDR_PORT0_DIR  = 16'hff20;
  localparam logic [15:0] DTC_ADDR_MODE_A     = 16'hff6d;
  localparam logic [15:0] DTC_ADDR_MODE_B     = 16'hff6e;
  localparam logic [15:0] DTC_ADDR_CARRIER    = 16'hff6f;
  localparam logic [15:0] DTC_ADDR_COMPARE_A  = 16'hff68;
  localparam logic [15:0] DTC_ADDR_COMPARE_B  = 16'hff69;
  localparam logic [15:0] DTC_ADDR_COUNTER_A  = 16'hff6a;
  localparam logic [15:0] DTC_ADDR_COUNTER_B  = 16'hff6b;
  // Reset values
  localparam logic [7:0]  DTC_RST_PORT0_DIR   = 8'hff;
  localparam logic [7:0]  DTC_RST_MODE        = 8'h00;
  localparam logic [7:0]  DTC_RST_CARRIER     = 8'h00;
  localparam logic [7:0]  DTC_RST_COMPARE     = 8'h00;
  // Writable bit masks, other bits read as zero
  localparam logic [7:0]  DTC_MASK_MODE_A     = 8'h9b;
  localparam logic [7:0]  DTC_MASK_MODE_B     = 8'hbf;
  // Field positions
  localparam int DTC_BIT_RUN       = 7;
  localparam int DTC_BIT_OE        = 0;
  localparam int DTC_BIT_MODE_A    = 1;
  localparam int DTC_POS_CLK_A     = 3;
  localparam int DTC_POS_CLK_B     = 3;
  localparam int DTC_POS_MODE_B    = 1;
  localparam int DTC_BIT_GATE      = 0;
  localparam int DTC_BIT_GATE_NEXT = 1;
  localparam int DTC_BIT_STEADY_HI = 2;
  localparam int DTC_BIT_PIN6      = 6;
  localparam int DTC_BIT_PIN7      = 7;
  // Prescaler divisors of the system clock
  localparam logic [5:0]  DTC_DIV16_MASK      = 6'h0f;
  localparam logic [5:0]  DTC_DIV64_MASK      = 6'h3f;
  localparam logic [5:0]  DTC_DIV4_MASK       = 6'h03;
  localparam logic [5:0]  DTC_DIV8_MASK       = 6'h07;
  // Mode codes {mode_sel_a, mode_sel_b_hi, mode_sel_b_lo}
  localparam logic [2:0]  DTC_MODE_DISCRETE   = 3'h0;
  localparam logic [2:0]  DTC_MODE_CASCADE    = 3'h5;
  localparam logic [2:0]  DTC_MODE_CARRIER    = 3'h3;
  localparam logic [2:0]  DTC_MODE_PWM_B      = 3'h2;
  // Clock select codes
  localparam logic [1:0]  DTC_CLKA_DIV16      = 2'h0;
  localparam logic [1:0]  DTC_CLKA_DIV64      = 2'h1;
  localparam logic [1:0]  DTC_CLKA_MATCH_B    = 2'h2;
  localparam logic [1:0]  DTC_CLKA_OUT_B      = 2'h3;
  localparam logic [2:0]  DTC_CLKB_DIV4       = 3'h0;
  localparam logic [2:0]  DTC_CLKB_DIV8       = 3'h1;
  localparam logic [2:0]  DTC_CLKB_EXT1       = 3'h2;
  localparam logic [2:0]  DTC_CLKB_EXT2       = 3'h3;
  localparam logic [2:0]  DTC_CLKB_EXT4       = 3'h4;
  localparam logic [2:0]  DTC_CLKB_EXT8       = 3'h5;
  localparam logic [7:0]  DTC_COUNT_TOP       = 8'hff;
endpackage

// ===== hw/dtc_timer_unit.sv
// One 8-bit counter with its square-wave flip-flop
`timescale 1ns/1ps
module dtc_timer_unit #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             tick_i,
  input  wire logic             run_i,
  input  wire logic             wrap_i,
  input  wire logic             toggle_i,
  input  wire logic             oe_i,
  // State
  output logic [WIDTH-1:0]      count_o,
  output logic                  wave_o
);
  // Elaboration-time check; a zero-width counter cannot hold a count
  if (WIDTH < 1) begin : g_width_check
    $error("dtc_timer_unit: WIDTH must be at least 1");
  end

  // Count; stopping clears, wrap or overflow returns to zero
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= '0;
    end else if (!run_i) begin
      count_o <= '0;
    end else if (tick_i) begin
      count_o <= wrap_i ? '0 : WIDTH'(count_o + 1'b1);
    end
  end

  // Square wave starts low and is forced low when stopped
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wave_o <= 1'b0;
    end else if (!run_i || !oe_i) begin
      wave_o <= 1'b0;
    end else if (toggle_i) begin
      wave_o <= ~wave_o;
    end
  end
endmodule

// ===== hw/dtc_top.sv
// Dual 8-bit cascadable timer with port-0 direction register
//
// Contract
// - In carrier mode, gate 0 drives timer output B low; gate 1 gives carrier or high.
// - Gate bit accepts writes only while timer output B is disabled.
// - Each direction bit: 0 drives the pin, 1 leaves it input.
// - Direction register resets to all ones, every pin input.
// - On match, counter clears at next count and raises its interrupt.
// - Timer A clock: fx/16, fx/64, B match, or B output.
// - Timer B clock: fx/4, fx/8, or external input over 1,2,4,8.
// - Match interval equals compare plus one count periods.
// - Only counter B counts external input edges.
// - Square wave inverts output on each match.
// - Square wave starts low and is forced low when stopped.
// - Square wave period is twice compare plus one count periods.
// - Cascade: counter A upper byte, counter B lower byte.
// - Cascade: run bit B starts and clears both, run A ignored.
// - Cascade: joint match clears both and raises only interrupt B.
// - Mode code: 000 discrete, 101 cascade, 011 carrier, 010 PWM (code 010 runs as discrete here).
// - Clearing run bit clears and stops the counter.
// - Counter returns to zero on overflow; cascade wraps together.
`timescale 1ns/1ps
module dtc_top
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Register access
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Pins
  input  wire logic        event_input_b_i,
  output logic             timer_out_a_o,
  output logic             timer_out_b_o,
  output logic      [7:0]  port0_oe_n_o,
  // Interrupt requests
  output logic             match_irq_a_o,
  output logic             match_irq_b_o
);
  import dtc_pkg::*;

  logic [7:0] port0_direction_reg;
  logic [7:0] mode_a_reg;
  logic [7:0] mode_b_reg;
  logic [7:0] carrier_out_ctrl_reg;
  logic [7:0] compare_a_reg;
  logic [7:0] compare_b_reg;
  logic [5:0] presc_reg;
  logic [1:0] ext_sync_reg;
  logic       ext_prev_reg;
  logic [2:0] ext_div_reg;
  logic       wave_b_prev_reg;
  logic       out_a_reg;
  logic       out_b_reg;
  logic [7:0] counter_a;
  logic [7:0] counter_b;
  logic       wave_a;
  logic       wave_b;

  // Prescaler tap: true once per divisor period
  function automatic logic tap(input logic [5:0] cnt,
                               input logic [5:0] mask);
    tap = ((cnt & mask) == mask);
  endfunction

  // Control field decode
  wire        run_a          = mode_a_reg[DTC_BIT_RUN];
  wire        run_b          = mode_b_reg[DTC_BIT_RUN];
  wire        out_enable_a   = mode_a_reg[DTC_BIT_OE];
  wire        out_enable_b   = mode_b_reg[DTC_BIT_OE];
  wire [1:0]  clk_sel_a      = mode_a_reg[DTC_POS_CLK_A +: 2];
  wire [2:0]  clk_sel_b      = mode_b_reg[DTC_POS_CLK_B +: 3];
  wire [2:0]  mode_code      = {mode_a_reg[DTC_BIT_MODE_A],
                                mode_b_reg[DTC_POS_MODE_B +: 2]};
  wire        cascade        = (mode_code == DTC_MODE_CASCADE);
  wire        carrier_mode   = (mode_code == DTC_MODE_CARRIER);
  wire        carrier_gate   = carrier_out_ctrl_reg[DTC_BIT_GATE];
  wire        carrier_gate_next =
                carrier_out_ctrl_reg[DTC_BIT_GATE_NEXT];
  wire        steady_high    = carrier_out_ctrl_reg[DTC_BIT_STEADY_HI];
  wire        run_a_eff      = cascade ? run_b : run_a;

  // External edge, read only from the second synchroniser stage
  wire        ext_rise       = ext_sync_reg[1] & ~ext_prev_reg;
  wire        ext_tick_2     = ext_rise & ext_div_reg[0];
  wire        ext_tick_4     = ext_rise & (&ext_div_reg[1:0]);
  wire        ext_tick_8     = ext_rise & (&ext_div_reg);

  // Timer B count clock select
  logic       sel_b;
  always_comb begin
    case (clk_sel_b)
      DTC_CLKB_DIV4: sel_b = tap(presc_reg, DTC_DIV4_MASK);
      DTC_CLKB_DIV8: sel_b = tap(presc_reg, DTC_DIV8_MASK);
      DTC_CLKB_EXT1: sel_b = ext_rise;
      DTC_CLKB_EXT2: sel_b = ext_tick_2;
      DTC_CLKB_EXT4: sel_b = ext_tick_4;
      DTC_CLKB_EXT8: sel_b = ext_tick_8;
      default:       sel_b = 1'b0;  // Prohibited codes never count
    endcase
  end

  // Compare against the live compare register, so updates act at once
  wire        match_b  = (counter_b == compare_b_reg);
  wire        match_a  = (counter_a == compare_a_reg);
  wire        joint    = match_a & match_b;
  wire        tick_b   = run_b & sel_b;
  wire        wrap_b   = cascade ? joint : match_b;
  wire        event_b  = tick_b & wrap_b;
  wire        wave_b_rise = wave_b & ~wave_b_prev_reg;

  // Timer A count clock select; cascade carries from counter B
  logic       sel_a;
  always_comb begin
    case (clk_sel_a)
      DTC_CLKA_DIV16:   sel_a = tap(presc_reg, DTC_DIV16_MASK);
      DTC_CLKA_DIV64:   sel_a = tap(presc_reg, DTC_DIV64_MASK);
      DTC_CLKA_MATCH_B: sel_a = event_b;
      DTC_CLKA_OUT_B:   sel_a = wave_b_rise;
      default:          sel_a = 1'b0;
    endcase
  end

  wire        carry_b  = tick_b & (joint | (counter_b == DTC_COUNT_TOP));
  wire        tick_a   = cascade ? carry_b : (run_a & sel_a);
  wire        wrap_a   = cascade ? joint : match_a;
  wire        event_a  = tick_a & wrap_a & ~cascade;

  // Register decode
  wire        wr_dir   = reg_wr_i & (reg_addr_i == DTC_ADDR_PORT0_DIR);
  wire        wr_mode_a = reg_wr_i & (reg_addr_i == DTC_ADDR_MODE_A);
  wire        wr_mode_b = reg_wr_i & (reg_addr_i == DTC_ADDR_MODE_B);
  wire        wr_carr  = reg_wr_i & (reg_addr_i == DTC_ADDR_CARRIER);
  wire        wr_cmp_a = reg_wr_i & (reg_addr_i == DTC_ADDR_COMPARE_A);
  wire        wr_cmp_b = reg_wr_i & (reg_addr_i == DTC_ADDR_COMPARE_B);
  wire        reload_gate = carrier_mode & event_a;

  // Gate bit is locked while output B is enabled, so a running
  // carrier cannot glitch; the reload path still updates it
  wire        carrier_gate_new =
                wr_carr & ~out_enable_b ? reg_wdata_i[DTC_BIT_GATE]
              : reload_gate ? carrier_gate_next : carrier_gate;
  wire [7:0]  carrier_next =
                wr_carr ? {5'h00, reg_wdata_i[DTC_BIT_STEADY_HI],
                           reg_wdata_i[DTC_BIT_GATE_NEXT],
                           carrier_gate_new}
                        : {carrier_out_ctrl_reg[7:1], carrier_gate_new};

  // Read data mux, unmapped addresses read zero
  logic [7:0] rdata_next;
  always_comb begin
    case (reg_addr_i)
      DTC_ADDR_PORT0_DIR: rdata_next = port0_direction_reg;
      DTC_ADDR_MODE_A:    rdata_next = mode_a_reg;
      DTC_ADDR_MODE_B:    rdata_next = mode_b_reg;
      DTC_ADDR_CARRIER:   rdata_next = carrier_out_ctrl_reg;
      DTC_ADDR_COMPARE_A: rdata_next = compare_a_reg;
      DTC_ADDR_COMPARE_B: rdata_next = compare_b_reg;
      DTC_ADDR_COUNTER_A: rdata_next = counter_a;
      DTC_ADDR_COUNTER_B: rdata_next = counter_b;
      default:            rdata_next = 8'h00;
    endcase
  end

  // Software registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port0_direction_reg  <= DTC_RST_PORT0_DIR;
      mode_a_reg           <= DTC_RST_MODE;
      mode_b_reg           <= DTC_RST_MODE;
      carrier_out_ctrl_reg <= DTC_RST_CARRIER;
      compare_a_reg        <= DTC_RST_COMPARE;
      compare_b_reg        <= DTC_RST_COMPARE;
      reg_rdata_o          <= 8'h00;
    end else begin
      if (wr_dir)    port0_direction_reg <= reg_wdata_i;
      if (wr_mode_a) mode_a_reg <= reg_wdata_i & DTC_MASK_MODE_A;
      if (wr_mode_b) mode_b_reg <= reg_wdata_i & DTC_MASK_MODE_B;
      if (wr_cmp_a)  compare_a_reg <= reg_wdata_i;
      if (wr_cmp_b)  compare_b_reg <= reg_wdata_i;
      carrier_out_ctrl_reg <= carrier_next;
      if (reg_rd_i)  reg_rdata_o <= rdata_next;
    end
  end

  // Prescaler, input synchroniser and edge divider
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_reg       <= 6'h00;
      ext_sync_reg    <= 2'h0;
      ext_prev_reg    <= 1'b0;
      ext_div_reg     <= 3'h0;
      wave_b_prev_reg <= 1'b0;
    end else begin
      presc_reg       <= 6'(presc_reg + 1'b1);
      ext_sync_reg    <= {ext_sync_reg[0], event_input_b_i};
      ext_prev_reg    <= ext_sync_reg[1];
      if (!run_b)        ext_div_reg <= 3'h0;
      else if (ext_rise) ext_div_reg <= 3'(ext_div_reg + 1'b1);
      wave_b_prev_reg <= wave_b;
    end
  end

  // Counter A is upper byte, counter B lower byte in cascade
  dtc_timer_unit #(.WIDTH(8)) u_timer_a (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (tick_a),
    .run_i      (run_a_eff),
    .wrap_i     (wrap_a),
    .toggle_i   (event_a),
    .oe_i       (out_enable_a),
    .count_o    (counter_a),
    .wave_o     (wave_a)
  );

  dtc_timer_unit #(.WIDTH(8)) u_timer_b (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (tick_b),
    .run_i      (run_b),
    .wrap_i     (wrap_b),
    .toggle_i   (event_b),
    .oe_i       (out_enable_b),
    .count_o    (counter_b),
    .wave_o     (wave_b)
  );

  // Pin drivers; gate only matters in carrier mode
  wire out_b_next = out_enable_b &
                    (carrier_mode ? (carrier_gate &
                                     (steady_high | wave_b))
                                  : wave_b);
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_a_reg     <= 1'b0;
      out_b_reg     <= 1'b0;
      match_irq_a_o <= 1'b0;
      match_irq_b_o <= 1'b0;
    end else begin
      out_a_reg     <= out_enable_a & wave_a;
      out_b_reg     <= out_b_next;
      match_irq_a_o <= event_a;
      match_irq_b_o <= event_b;
    end
  end

  assign timer_out_a_o = out_a_reg;
  assign timer_out_b_o = out_b_reg;
  assign port0_oe_n_o  = port0_direction_reg;

  // Checks
  property p_gate_low;
    @(posedge core_clk_i) disable iff (!nrst_i)
    carrier_mode & ~carrier_gate |=> ~timer_out_b_o;
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("output B high with gate closed");

  property p_gate_lock;
    @(posedge core_clk_i) disable iff (!nrst_i)
    wr_carr & out_enable_b & ~reload_gate |=> $stable(carrier_gate);
  endproperty
  a_gate_lock: assert property (p_gate_lock)
    else $error("gate written while output B enabled");

  property p_dir_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
    wr_dir |=> port0_oe_n_o == $past(reg_wdata_i);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not applied");

  property p_match_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ~cascade & tick_b & match_b |=> counter_b == 8'h00 && match_irq_b_o;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("counter B not cleared on match");

  property p_irq_pulse;
    @(posedge core_clk_i) disable iff (!nrst_i)
    match_irq_b_o |=> ~match_irq_b_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt B longer than one cycle");

  property p_casc_no_a;
    @(posedge core_clk_i) disable iff (!nrst_i)
    cascade & $past(cascade) |-> ~match_irq_a_o;
  endproperty
  a_casc_no_a: assert property (p_casc_no_a)
    else $error("interrupt A raised in cascade");

  property p_stop_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ~run_b |=> counter_b == 8'h00 && (!$past(cascade) || counter_a == 8'h00);
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stopped counter not cleared");

  property p_wave_stop;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ~run_a_eff |=> ~wave_a ##1 ~timer_out_a_o;
  endproperty
  a_wave_stop: assert property (p_wave_stop)
    else $error("square wave A not forced low");

  property p_casc_carry;
    @(posedge core_clk_i) disable iff (!nrst_i)
    cascade & run_b & tick_b & (counter_b == 8'hff) & ~joint
      |=> counter_a == 8'($past(counter_a) + 1'b1) && counter_b == 8'h00;
  endproperty
  a_casc_carry: assert property (p_casc_carry)
    else $error("cascade carry lost");

  c_irq_b:   cover property (@(posedge core_clk_i) match_irq_b_o);
  c_irq_a:   cover property (@(posedge core_clk_i) match_irq_a_o);
  c_joint:   cover property (@(posedge core_clk_i) cascade & event_b);
  c_ext:     cover property (@(posedge core_clk_i) tick_b & ext_rise);
endmodule

// ===== dv/dtc_pulse_src.sv
// External pulse source driving the timer B count pin
`timescale 1ns/1ps
module dtc_pulse_src #(
  parameter int HALF_NS = 75
) (
  // Pin
  output logic pin_o
);
  // Idle low between bursts so no stray edge is seen
  initial pin_o = 1'b0;
  // Three clocks high and low, above the synchroniser minimum
  task automatic send(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      #(HALF_NS) pin_o = 1'b1;
      #(HALF_NS) pin_o = 1'b0;
    end
  endtask
endmodule

// ===== dv/dtc_top_test.sv
// Self-checking testbench for the dual cascadable timer
`timescale 1ns/1ps
module dtc_top_test;
  import dtc_pkg::*;
  logic        core_clk_i;
  logic        nrst_i;
  logic [15:0] reg_addr_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  wire logic   event_input_b_i;
  logic        timer_out_a_o;
  logic        timer_out_b_o;
  logic [7:0]  port0_oe_n_o;
  logic        match_irq_a_o;
  logic        match_irq_b_o;
  int          errors;
  int          checks_done;
  int          irq_a_cnt;

  dtc_top dtc_top_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .event_input_b_i(event_input_b_i), .timer_out_a_o(timer_out_a_o),
    .timer_out_b_o(timer_out_b_o), .port0_oe_n_o(port0_oe_n_o),
    .match_irq_a_o(match_irq_a_o), .match_irq_b_o(match_irq_b_o));
  dtc_pulse_src dtc_pulse_src_i (.pin_o(event_input_b_i));

  // 40 MHz system clock
  initial core_clk_i = 1'b0;
  always #12.5 core_clk_i = ~core_clk_i;
  // Interrupt A pulses, to prove cascade never raises it
  always @(negedge core_clk_i) begin
    if (match_irq_a_o === 1'b1) irq_a_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Byte writes only, so control bits are never touched singly
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk({24'h0, reg_rdata_o}, {24'h0, exp});
  endtask
  task automatic stop_all;
    wr(DTC_ADDR_MODE_A, 8'h00);
    wr(DTC_ADDR_MODE_B, 8'h00);
  endtask
  // Cycles between two consecutive match pulses
  task automatic gap(input bit sel, output logic [31:0] n);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(negedge core_clk_i);
      if ((sel ? match_irq_b_o : match_irq_a_o) === 1'b1) break;
    end
    for (k = 1; k < 5000; k++) begin
      @(negedge core_clk_i);
      if ((sel ? match_irq_b_o : match_irq_a_o) === 1'b1) break;
    end
    n = k;
  endtask
  // Cycles until the chosen timer output changes level
  task automatic flip(input bit sel, output logic [31:0] n);
    logic v;
    int k;
    v = sel ? timer_out_b_o : timer_out_a_o;
    for (k = 1; k < 5000; k++) begin
      @(negedge core_clk_i);
      if ((sel ? timer_out_b_o : timer_out_a_o) !== v) break;
    end
    n = k;
  endtask

  task automatic t_reset;
    rchk(DTC_ADDR_PORT0_DIR, DTC_RST_PORT0_DIR);
    chk({24'h0, port0_oe_n_o}, 32'hff);
    rchk(DTC_ADDR_CARRIER, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_dir;
    wr(DTC_ADDR_PORT0_DIR, 8'h35);
    chk({24'h0, port0_oe_n_o}, 32'h35);
    rchk(DTC_ADDR_PORT0_DIR, 8'h35);
    rchk(16'hff00, 8'h00);
    wr(DTC_ADDR_PORT0_DIR, 8'hbf);
    chk({24'h0, port0_oe_n_o}, 32'hbf);
    $display("direction test done");
  endtask
  // Stop, load compares, set clock and mode, then run
  task automatic t_int(input logic [7:0] ma, input logic [7:0] mb,
                       input logic [7:0] ca, input logic [7:0] cb,
                       input bit sel, input logic [31:0] exp);
    logic [31:0] n;
    stop_all();
    irq_a_cnt = 0;
    wr(DTC_ADDR_COMPARE_A, ca);
    wr(DTC_ADDR_COMPARE_B, cb);
    wr(DTC_ADDR_MODE_A, ma & 8'h7f);
    wr(DTC_ADDR_MODE_B, mb & 8'h7f);
    wr(DTC_ADDR_MODE_A, ma);
    wr(DTC_ADDR_MODE_B, mb);
    gap(sel, n);
    chk(n, exp);
    $display("interval test done");
  endtask
  task automatic t_square;
    logic [31:0] n;
    stop_all();
    wr(DTC_ADDR_COMPARE_B, 8'h03);
    wr(DTC_ADDR_MODE_B, 8'h01);
    chk({31'h0, timer_out_b_o}, 32'h0);
    wr(DTC_ADDR_MODE_B, 8'h81);
    flip(1'b1, n);
    flip(1'b1, n);
    chk(n, 32'd16);
    flip(1'b1, n);
    chk(n, 32'd16);
    wr(DTC_ADDR_MODE_B, 8'h01);
    repeat (3) @(negedge core_clk_i);
    chk({31'h0, timer_out_b_o}, 32'h0);
    rchk(DTC_ADDR_COUNTER_B, 8'h00);
    // Timer A square wave on fx/16, compare 1: half period 32 cycles
    stop_all();
    wr(DTC_ADDR_COMPARE_A, 8'h01);
    wr(DTC_ADDR_MODE_A, 8'h81);
    flip(1'b0, n);
    flip(1'b0, n);
    chk(n, 32'd32);
    wr(DTC_ADDR_MODE_A, 8'h01);
    repeat (3) @(negedge core_clk_i);
    chk({31'h0, timer_out_a_o}, 32'h0);
    $display("square test done");
  endtask
  // Every external clock code, pulse counts that divide evenly
  task automatic t_event;
    logic [2:0] code [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
    int         np   [4] = '{5, 6, 8, 8};
    logic [7:0] ex   [4] = '{8'h05, 8'h03, 8'h02, 8'h01};
    int i;
    for (i = 0; i < 4; i++) begin
      stop_all();
      wr(DTC_ADDR_COMPARE_B, 8'hff);
      wr(DTC_ADDR_MODE_B, {2'b00, code[i], 3'b000});
      wr(DTC_ADDR_MODE_B, {2'b10, code[i], 3'b000});
      dtc_pulse_src_i.send(np[i]);
      repeat (6) @(negedge core_clk_i);
      rchk(DTC_ADDR_COUNTER_B, ex[i]);
    end
    $display("event test done");
  endtask
  task automatic t_carrier;
    stop_all();
    wr(DTC_ADDR_MODE_B, 8'h06);
    wr(DTC_ADDR_CARRIER, 8'h01);
    rchk(DTC_ADDR_CARRIER, 8'h01);
    wr(DTC_ADDR_MODE_B, 8'h07);
    wr(DTC_ADDR_CARRIER, 8'h00);
    rchk(DTC_ADDR_CARRIER, 8'h01);
    wr(DTC_ADDR_MODE_B, 8'h06);
    wr(DTC_ADDR_CARRIER, 8'h04);
    wr(DTC_ADDR_MODE_B, 8'h07);
    repeat (3) @(negedge core_clk_i);
    chk({31'h0, timer_out_b_o}, 32'h0);
    wr(DTC_ADDR_MODE_B, 8'h06);
    wr(DTC_ADDR_CARRIER, 8'h05);
    wr(DTC_ADDR_MODE_B, 8'h07);
    repeat (3) @(negedge core_clk_i);
    chk({31'h0, timer_out_b_o}, 32'h1);
    $display("carrier test done");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the longest expected run
  initial begin
    #(1000000);
    errors++;
    results();
  end

  initial begin
    nrst_i = 1'b0;
    reg_addr_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    errors = 0;
    checks_done = 0;
    irq_a_cnt = 0;
    repeat (16) @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_dir();
    t_int(8'h00, 8'h80, 8'h00, 8'h00, 1'b1, 32'd4);
    t_int(8'h00, 8'h88, 8'h00, 8'h02, 1'b1, 32'd24);
    t_int(8'h00, 8'h80, 8'h00, 8'hff, 1'b1, 32'd1024);
    t_int(8'h80, 8'h00, 8'h01, 8'h00, 1'b0, 32'd32);
    t_int(8'h88, 8'h00, 8'h00, 8'h00, 1'b0, 32'd64);
    t_int(8'h90, 8'h80, 8'h02, 8'h01, 1'b0, 32'd24);
    t_int(8'h98, 8'h81, 8'h01, 8'h01, 1'b0, 32'd32);
    t_int(8'h02, 8'h82, 8'h01, 8'h02, 1'b1, 32'd1036);
    chk(irq_a_cnt, 32'd0);
    t_square();
    t_event();
    t_carrier();
    results();
  end
endmodule
